// File: logic/mcac_ctrl.sv
// Metering clock, reference, gain and converter control with Wishbone regs.
// Function
// - System control bit 7 picks oscillator or PLL; readback gives source.
// - System control bit 4 stops the root clock; clear after reset.
// - Root clock stopped: metering datapath and converters halt.
// - Gate bit stops sampling and calculation; accumulation keeps running.
// - Clock config bits 5:4 set sampling rate: 204.8 kHz times 1, 2, 4.
// - Clock config bits 3:2 set metering rate: 819.2 kHz times 1, 2, 4.
// - Chopper runs while trim bit 0 is clear; software keeps it clear.
// - Trim bits 5:1 hold a 3-bit and a 2-bit temperature trim.
// - Leak monitor enabled and reference drop sets the leak interrupt flag.
// - Interrupt when leak flag and leak, group, global enables are set.
// - Gain bit 6 sets voltage gain x1 or x2; software keeps default.
// - Gain bits 5:3 set channel B gain x1, x4, x8, x16, else x32.
// - Gain bits 2:0 set channel A gain with the same encoding.
// - Converters off after reset; enable bits 2, 1, 0 for U, B, A.
// - Converter output is 22 bits with bits 21 and 20 both sign.
//
// Added by the designer: register access over Wishbone.
module mcac_ctrl
    import mcac_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [15:0]         wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic      [31:0]         wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                ref_low_i,
    input  wire mcac_pkg::mcac_raw_t conv_raw_i,
    output mcac_pkg::mcac_conv_t     conv_o,
    output logic                     root_src_pll_o,
    output logic                     root_run_o,
    output logic                     metering_tick_o,
    output logic                     sampling_tick_o,
    output logic                     calc_run_o,
    output logic                     accum_run_o,
    output logic                     reference_enable_o,
    output logic                     reference_chopper_off_o,
    output logic [2:0]               reference_trim_coarse_o,
    output logic [1:0]               reference_trim_fine_o,
    output logic [2:0]               conv_enable_o,
    output mcac_pkg::mcac_gain_t     gain_shift_o,
    output logic                     offset_inject_disable_o,
    output logic                     irq_o
);
    import mcac_pkg::*;

    // Rate code 11 is undefined; it is treated as x4 so the rate stays bounded.
    function automatic logic [26:0] rate_inc(input logic [26:0] base,
                                             input logic [1:0]  code);
        rate_inc = (code == 2'b00) ? base :
                   (code == 2'b01) ? {base[25:0], 1'b0} :
                   {base[24:0], 2'b00};
    endfunction

    // Gain as a left shift: x1, x4, x8, x16, x32.
    function automatic logic [2:0] gain_shift(input logic [2:0] code);
        gain_shift = code[2] ? 3'h5 :
                     (code == 3'h0) ? 3'h0 : 3'(code + 3'h1);
    endfunction

    // Sign-extends a 21-bit sample so bits 21 and 20 both carry the sign.
    function automatic logic [OUT_W-1:0] fmt22(input logic [SMP_W-1:0] s);
        fmt22 = {s[SMP_W-1], s};
    endfunction

    logic [7:0]  sys_q, glob_q, group_q, flag_q, ien_q, gain_q;
    logic [7:0]  bias_q, xtal_q, trim_q, cen_q, ccfg_q, det_q;
    logic [26:0] macc_q, sacc_q;
    logic [26:0] macc_sum, sacc_sum;
    logic        leak_s1_q, leak_s2_q, leak_s3_q;
    logic        wr, rd_hit;
    logic [15:0] idx;
    logic [7:0]  rd_d;
    logic        run, calc;

    assign idx  = {2'b00, wb_adr_i[15:2]};
    assign wr   = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign run  = !sys_q[CLK_STOP_BIT];
    assign calc = run && !det_q[CALC_GATE_BIT];

    // Bus handshake: one wait state, ack for exactly one cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        unique case (idx)
            IDX_SYS_CTRL:  rd_d = sys_q;
            IDX_GLOB_IE:   rd_d = glob_q;
            IDX_GROUP_IE:  rd_d = group_q;
            IDX_IRQ_FLAG:  rd_d = flag_q;
            IDX_IRQ_EN:    rd_d = ien_q;
            IDX_GAIN:      rd_d = gain_q;
            IDX_DISP_BIAS: rd_d = bias_q;
            IDX_XTAL2:     rd_d = xtal_q;
            IDX_REF_TRIM:  rd_d = trim_q;
            IDX_CONV_EN:   rd_d = cen_q;
            IDX_CLK_CFG:   rd_d = ccfg_q;
            IDX_DET_CTRL:  rd_d = det_q;
            default: begin
                rd_d   = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
            wb_dat_o <= rd_hit ? {24'h00_0000, rd_d} : 32'h0000_0000;
        end
    end

    // Plain read-write registers; the source switch is immediate.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sys_q   <= REG_RST;
            glob_q  <= REG_RST;
            group_q <= REG_RST;
            ien_q   <= REG_RST;
            gain_q  <= REG_RST;
            bias_q  <= REG_RST;
            xtal_q  <= REG_RST;
            trim_q  <= REG_RST;
            cen_q   <= REG_RST;
            ccfg_q  <= REG_RST;
            det_q   <= REG_RST;
        end else if (wr) begin
            unique case (idx)
                IDX_SYS_CTRL:  sys_q   <= wb_dat_i[7:0];
                IDX_GLOB_IE:   glob_q  <= wb_dat_i[7:0];
                IDX_GROUP_IE:  group_q <= wb_dat_i[7:0];
                IDX_IRQ_EN:    ien_q   <= wb_dat_i[7:0];
                IDX_GAIN:      gain_q  <= wb_dat_i[7:0];
                IDX_DISP_BIAS: bias_q  <= wb_dat_i[7:0];
                IDX_XTAL2:     xtal_q  <= wb_dat_i[7:0];
                IDX_REF_TRIM:  trim_q  <= wb_dat_i[7:0];
                IDX_CONV_EN:   cen_q   <= wb_dat_i[7:0];
                IDX_CLK_CFG:   ccfg_q  <= wb_dat_i[7:0];
                IDX_DET_CTRL:  det_q   <= wb_dat_i[7:0];
                default: ;
            endcase
        end
    end

    // The reference comparator is asynchronous to this clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            leak_s1_q <= 1'b0;
            leak_s2_q <= 1'b0;
            leak_s3_q <= 1'b0;
        end else begin
            leak_s1_q <= ref_low_i;
            leak_s2_q <= leak_s1_q;
            leak_s3_q <= leak_s2_q;
        end
    end

    logic leak_evt;
    assign leak_evt = leak_s2_q && !leak_s3_q && xtal_q[LEAK_EN_BIT];

    // Write one to clear; a new event in the same cycle keeps the flag.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= REG_RST;
        end else begin
            if (wr && idx == IDX_IRQ_FLAG) begin
                flag_q <= flag_q & ~wb_dat_i[7:0];
            end
            if (leak_evt) begin
                flag_q[LEAK_IRQ_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (|(flag_q & ien_q)) && group_q[GROUP_IE_BIT]
                     && glob_q[GLOB_IE_BIT];
        end
    end

    // Fractional dividers give the exact average rate from the 100 MHz clock.
    assign macc_sum = macc_q + rate_inc(MTR_BASE_HZ, ccfg_q[MTR_SEL_LSB+:2]);
    assign sacc_sum = sacc_q + rate_inc(SMP_BASE_HZ, ccfg_q[SMP_SEL_LSB+:2]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            macc_q          <= 27'h000_0000;
            metering_tick_o <= 1'b0;
        end else if (!run) begin
            metering_tick_o <= 1'b0;
        end else if (macc_sum >= CLK_HZ) begin
            macc_q          <= macc_sum - CLK_HZ;
            metering_tick_o <= 1'b1;
        end else begin
            macc_q          <= macc_sum;
            metering_tick_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sacc_q          <= 27'h000_0000;
            sampling_tick_o <= 1'b0;
        end else if (!calc) begin
            sampling_tick_o <= 1'b0;
        end else if (sacc_sum >= CLK_HZ) begin
            sacc_q          <= sacc_sum - CLK_HZ;
            sampling_tick_o <= 1'b1;
        end else begin
            sacc_q          <= sacc_sum;
            sampling_tick_o <= 1'b0;
        end
    end

    // Results move only on a sampling tick, so a halted clock freezes them.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_o <= '0;
        end else if (calc && sacc_sum >= CLK_HZ) begin
            if (cen_q[CONV_U_BIT]) conv_o.u <= fmt22(conv_raw_i.u);
            if (cen_q[CONV_B_BIT]) conv_o.b <= fmt22(conv_raw_i.b);
            if (cen_q[CONV_A_BIT]) conv_o.a <= fmt22(conv_raw_i.a);
        end
    end

    // Status outputs are decoded from the registers one cycle late.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            root_src_pll_o          <= 1'b0;
            root_run_o              <= 1'b0;
            calc_run_o              <= 1'b0;
            accum_run_o             <= 1'b0;
            reference_enable_o      <= 1'b0;
            reference_chopper_off_o <= 1'b0;
            reference_trim_coarse_o <= 3'h0;
            reference_trim_fine_o   <= 2'h0;
            conv_enable_o           <= 3'h0;
            gain_shift_o            <= '0;
            offset_inject_disable_o <= 1'b0;
        end else begin
            root_src_pll_o          <= sys_q[SRC_SEL_BIT];
            root_run_o              <= run;
            calc_run_o              <= calc;
            accum_run_o             <= run;
            reference_enable_o      <= ccfg_q[REF_EN_BIT];
            reference_chopper_off_o <= trim_q[CHOP_OFF_BIT];
            reference_trim_coarse_o <= trim_q[TRIM_CRS_LSB+:3];
            reference_trim_fine_o   <= trim_q[TRIM_FIN_LSB+:2];
            conv_enable_o           <= run ? cen_q[2:0] : 3'h0;
            gain_shift_o.u <= gain_q[VGAIN_BIT] ? 3'h1 : 3'h0;
            gain_shift_o.b <= gain_shift(gain_q[GAIN_B_LSB+:3]);
            gain_shift_o.a <= gain_shift(gain_q[GAIN_A_LSB+:3]);
            offset_inject_disable_o <= bias_q[OFS_DIS_BIT];
        end
    end

    property p_src_sel;
        @(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_SYS_CTRL |-> ##2
            root_src_pll_o == $past(wb_dat_i[SRC_SEL_BIT], 2);
    endproperty
    a_src_sel: assert property (p_src_sel)
        else $error("source select lost");

    property p_stop;
        @(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_SYS_CTRL && wb_dat_i[CLK_STOP_BIT]
            |-> ##2 !root_run_o;
    endproperty
    a_stop: assert property (p_stop)
        else $error("root clock not stopped");

    property p_halt;
        @(posedge clk_i) disable iff (rst_i)
        !run |=> !metering_tick_o && !sampling_tick_o && $stable(conv_o);
    endproperty
    a_halt: assert property (p_halt)
        else $error("datapath ran while stopped");

    property p_gate;
        @(posedge clk_i) disable iff (rst_i)
        run && det_q[CALC_GATE_BIT]
            |=> !sampling_tick_o && !calc_run_o && accum_run_o;
    endproperty
    a_gate: assert property (p_gate)
        else $error("calc gate misbehaves");

    property p_smp_rate;
        @(posedge clk_i) disable iff (rst_i)
        sampling_tick_o |=> !sampling_tick_o [*8];
    endproperty
    a_smp_rate: assert property (p_smp_rate)
        else $error("sampling too fast");

    property p_mtr_rate;
        @(posedge clk_i) disable iff (rst_i)
        run && ccfg_q[MTR_SEL_LSB+:2] == 2'b00 && metering_tick_o
            |=> !metering_tick_o [*8];
    endproperty
    a_mtr_rate: assert property (p_mtr_rate)
        else $error("metering too fast");

    property p_chop;
        @(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_REF_TRIM |-> ##2
            reference_chopper_off_o == $past(wb_dat_i[CHOP_OFF_BIT], 2);
    endproperty
    a_chop: assert property (p_chop)
        else $error("chopper control lost");

    property p_trim;
        @(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_REF_TRIM |-> ##2
            {reference_trim_coarse_o, reference_trim_fine_o}
            == $past(wb_dat_i[TRIM_FIN_LSB+:5], 2);
    endproperty
    a_trim: assert property (p_trim)
        else $error("trim fields lost");

    property p_leak;
        @(posedge clk_i) disable iff (rst_i)
        leak_evt |=> flag_q[LEAK_IRQ_BIT];
    endproperty
    a_leak: assert property (p_leak)
        else $error("leak flag not set");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        flag_q[LEAK_IRQ_BIT] && ien_q[LEAK_IRQ_BIT] && group_q[GROUP_IE_BIT]
            && glob_q[GLOB_IE_BIT] |=> irq_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    property p_gain_u;
        @(posedge clk_i) disable iff (rst_i)
        wr && idx == IDX_GAIN |-> ##2
            gain_shift_o.u == {2'b00, $past(wb_dat_i[VGAIN_BIT], 2)};
    endproperty
    a_gain_u: assert property (p_gain_u)
        else $error("voltage gain lost");

    property p_gain_b;
        @(posedge clk_i) disable iff (rst_i)
        gain_q[GAIN_B_LSB+2] |=> gain_shift_o.b == 3'h5;
    endproperty
    a_gain_b: assert property (p_gain_b)
        else $error("gain B not x32");

    property p_gain_a;
        @(posedge clk_i) disable iff (rst_i)
        gain_q[GAIN_A_LSB+:3] == 3'h1 |=> gain_shift_o.a == 3'h2;
    endproperty
    a_gain_a: assert property (p_gain_a)
        else $error("gain A not x4");

    property p_conv_rst;
        @(posedge clk_i) rst_i |=> cen_q == 8'h00 && conv_enable_o == 3'h0;
    endproperty
    a_conv_rst: assert property (p_conv_rst)
        else $error("converters on at reset");

    property p_fmt;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |-> conv_o.u[21] == conv_o.u[20] && conv_o.b[21] == conv_o.b[20]
            && conv_o.a[21] == conv_o.a[20];
    endproperty
    a_fmt: assert property (p_fmt)
        else $error("sign bits differ");
endmodule

// File: logic/mcac_pkg.sv
// Package with the register map, field positions and types of the block.
package mcac_pkg;
    // Register indices; the byte address is four times the index.
    localparam logic [15:0] IDX_SYS_CTRL  = 16'h0080;
    localparam logic [15:0] IDX_GLOB_IE   = 16'h00A8;
    localparam logic [15:0] IDX_GROUP_IE  = 16'h00E8;
    localparam logic [15:0] IDX_IRQ_FLAG  = 16'h2850;
    localparam logic [15:0] IDX_IRQ_EN    = 16'h2853;
    localparam logic [15:0] IDX_GAIN      = 16'h2858;
    localparam logic [15:0] IDX_DISP_BIAS = 16'h285E;
    localparam logic [15:0] IDX_XTAL2     = 16'h2861;
    localparam logic [15:0] IDX_REF_TRIM  = 16'h2862;
    localparam logic [15:0] IDX_CONV_EN   = 16'h2864;
    localparam logic [15:0] IDX_CLK_CFG   = 16'h2867;
    localparam logic [15:0] IDX_DET_CTRL  = 16'h2886;

    // Field positions.
    localparam int SRC_SEL_BIT   = 7;
    localparam int CLK_STOP_BIT  = 4;
    localparam int CALC_GATE_BIT = 7;
    localparam int REF_EN_BIT    = 6;
    localparam int SMP_SEL_LSB   = 4;
    localparam int MTR_SEL_LSB   = 2;
    localparam int CHOP_OFF_BIT  = 0;
    localparam int TRIM_CRS_LSB  = 3;
    localparam int TRIM_FIN_LSB  = 1;
    localparam int LEAK_EN_BIT   = 7;
    localparam int LEAK_IRQ_BIT  = 4;
    localparam int GROUP_IE_BIT  = 2;
    localparam int GLOB_IE_BIT   = 7;
    localparam int VGAIN_BIT     = 6;
    localparam int GAIN_B_LSB    = 3;
    localparam int GAIN_A_LSB    = 0;
    localparam int CONV_U_BIT    = 2;
    localparam int CONV_B_BIT    = 1;
    localparam int CONV_A_BIT    = 0;
    localparam int OFS_DIS_BIT   = 7;

    // Reset value shared by every register.
    localparam logic [7:0] REG_RST = 8'h00;

    // Rates in hertz; the tick generators divide the system clock down to them.
    localparam logic [26:0] CLK_HZ      = 27'h5F5_E100;
    localparam logic [26:0] MTR_BASE_HZ = 27'h00C_8000;
    localparam logic [26:0] SMP_BASE_HZ = 27'h003_2000;

    localparam int SMP_W = 21;
    localparam int OUT_W = 22;

    typedef struct packed {
        logic [SMP_W-1:0] u;
        logic [SMP_W-1:0] b;
        logic [SMP_W-1:0] a;
    } mcac_raw_t;

    typedef struct packed {
        logic [OUT_W-1:0] u;
        logic [OUT_W-1:0] b;
        logic [OUT_W-1:0] a;
    } mcac_conv_t;

    typedef struct packed {
        logic [2:0] u;
        logic [2:0] b;
        logic [2:0] a;
    } mcac_gain_t;
endpackage

// File: verif/tb.sv
// Self-checking testbench of the metering clock and converter control block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import mcac_pkg::*;

    typedef struct packed {
        logic [15:0] idx;
        logic [7:0]  dat;
        logic [7:0]  rd;
    } mcac_row_t;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic [15:0] wb_adr = 16'h0000;
    logic [3:0]  wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        ref_low = 1'b0;
    mcac_raw_t   raw = '0;
    mcac_conv_t  conv_o;
    mcac_gain_t  gain_o;
    logic        src_o, run_o, mtick_o, stick_o, calc_o, accum_o, ref_en_o;
    logic        chop_o, ofs_o, irq_o;
    logic [2:0]  coarse_o, cen_o;
    logic [1:0]  fine_o;
    int          err_count = 0;
    int          checks_done = 0;
    logic [7:0]  q;
    int          mc, sc, e;
    mcac_row_t   rows [11];

    mcac_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .ref_low_i(ref_low), .conv_raw_i(raw),
        .conv_o(conv_o), .root_src_pll_o(src_o), .root_run_o(run_o),
        .metering_tick_o(mtick_o), .sampling_tick_o(stick_o),
        .calc_run_o(calc_o), .accum_run_o(accum_o),
        .reference_enable_o(ref_en_o), .reference_chopper_off_o(chop_o),
        .reference_trim_coarse_o(coarse_o), .reference_trim_fine_o(fine_o),
        .conv_enable_o(cen_o), .gain_shift_o(gain_o),
        .offset_inject_disable_o(ofs_o), .irq_o(irq_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    // The request is held until ack is sampled high at a rising edge.
    task automatic wb(input logic [15:0] idx, input logic [7:0] d,
                      input logic we, input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {idx[13:0], 2'b00};
        wb_sel <= sel;
        wb_dat <= {24'h000000, d};
        // Only the watchdog ends this wait; the slave sets the pace.
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        chk("wb_ack", wb_ack_o, 1'b1);
        q = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        wb(idx, d, 1'b1, 4'hF);
        @(posedge clk_i);
        #1;
    endtask

    task automatic rd(input logic [15:0] idx);
        wb(idx, 8'h00, 1'b0, 4'hF);
    endtask

    task automatic ticks(input int n);
        mc = 0;
        sc = 0;
        repeat (n) begin
            @(posedge clk_i);
            mc += int'(mtick_o === 1'b1);
            sc += int'(stick_o === 1'b1);
        end
        #1;
    endtask

    task automatic wait_smp();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (stick_o !== 1'b1 && n < 2000);
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    initial begin
        // The scenarios need about 34000 cycles; this leaves ample margin.
        repeat (60000) @(posedge clk_i);
        err_count++;
        end_of_test();
    end

    initial begin
        // Reference first, then the PLL source, then the converters.
        rows = '{'{IDX_CLK_CFG, 8'h40, 8'h40},
                 '{IDX_SYS_CTRL, 8'h80, 8'h80},
                 '{IDX_REF_TRIM, 8'h2A, 8'h2A},
                 '{IDX_GAIN, 8'h2A, 8'h2A},
                 '{IDX_CONV_EN, 8'h07, 8'h07},
                 '{IDX_DISP_BIAS, 8'h7F, 8'h7F},
                 '{IDX_XTAL2, 8'h80, 8'h80}, '{IDX_IRQ_EN, 8'h10, 8'h10},
                 '{IDX_GROUP_IE, 8'h04, 8'h04}, '{IDX_GLOB_IE, 8'h80, 8'h80},
                 '{16'h0001, 8'hFF, 8'h00}};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        chk("root_run", run_o, 1'b1);
        chk("conv_en", cen_o, 3'b000);
        foreach (rows[i]) begin
            rd(rows[i].idx);
            chk("reset_value", q, REG_RST);
            wr(rows[i].idx, rows[i].dat);
            rd(rows[i].idx);
            chk("readback", q, rows[i].rd);
        end
        chk("src_pll", src_o, 1'b1);
        chk("ref_en", ref_en_o, 1'b1);
        chk("trim", {chop_o, coarse_o, fine_o}, 6'b0_101_01);
        chk("conv_en", cen_o, 3'b111);
        chk("ofs_dis", ofs_o, 1'b0);
        wr(IDX_REF_TRIM, 8'h3F);
        chk("trim", {chop_o, coarse_o, fine_o}, 6'b1_111_11);
        // Gain codes with the top bit set all give the largest gain.
        for (int c = 0; c < 8; c++) begin
            wr(IDX_GAIN, {1'b0, c[0], c[2:0], c[2:0]});
            e = (c > 4) ? 5 : ((c == 0) ? 0 : c + 1);
            chk("gain_u", gain_o.u, {2'b00, c[0]});
            chk("gain_ba", {gain_o.b, gain_o.a}, {e[2:0], e[2:0]});
        end
        wb(IDX_GAIN, 8'h3F, 1'b1, 4'hE);
        rd(IDX_GAIN);
        chk("sel_ignored", q, 8'h7F);
        for (int c = 0; c < 3; c++) begin
            wr(IDX_CLK_CFG, 8'h40 | (c[1:0] << 4) | (c[1:0] << 2));
            ticks(10000);
            e = (8192 * 10000 * (1 << c)) / 1000000;
            chk("mtr_rate", mc >= e && mc <= e + 1, 1'b1);
            e = (2048 * 10000 * (1 << c)) / 1000000;
            chk("smp_rate", sc >= e && sc <= e + 1, 1'b1);
        end
        @(posedge clk_i);
        raw <= '{u: 21'h100000, b: 21'h0FFFFF, a: 21'h000005};
        wait_smp();
        chk("conv", conv_o, {22'h300000, 22'h0FFFFF, 22'h000005});
        wr(IDX_CONV_EN, 8'h06);
        @(posedge clk_i);
        raw.a <= 21'h1FFFFF;
        wait_smp();
        chk("conv_a_off", conv_o.a, 22'h000005);
        wr(IDX_DET_CTRL, 8'h80);
        chk("calc_accum", {calc_o, accum_o}, 2'b01);
        @(posedge clk_i);
        raw.u <= 21'h000003;
        ticks(2000);
        chk("gate_smp", sc, 0);
        chk("gate_mtr", mc >= 65 && mc <= 66, 1'b1);
        chk("gate_conv", conv_o.u, 22'h300000);
        wr(IDX_DET_CTRL, 8'h00);
        wr(IDX_SYS_CTRL, 8'h90);
        chk("stopped", {run_o, cen_o}, 4'b0000);
        @(posedge clk_i);
        raw.u <= 21'h000007;
        ticks(1000);
        chk("stop_ticks", mc + sc, 0);
        chk("stop_conv", conv_o.u, 22'h300000);
        wr(IDX_SYS_CTRL, 8'h00);
        chk("src_osc", {src_o, run_o}, 2'b01);
        wr(IDX_SYS_CTRL, 8'h80);
        @(posedge clk_i);
        ref_low <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk("irq_on", irq_o, 1'b1);
        rd(IDX_IRQ_FLAG);
        chk("leak_flag", q, 8'h10);
        wr(IDX_GLOB_IE, 8'h00);
        chk("irq_glob_mask", irq_o, 1'b0);
        wr(IDX_GLOB_IE, 8'h80);
        wr(IDX_GROUP_IE, 8'h00);
        chk("irq_group_mask", irq_o, 1'b0);
        wr(IDX_GROUP_IE, 8'h04);
        wr(IDX_IRQ_EN, 8'h00);
        chk("irq_leak_mask", irq_o, 1'b0);
        wr(IDX_IRQ_EN, 8'h10);
        chk("irq_back", irq_o, 1'b1);
        wr(IDX_IRQ_FLAG, 8'h10);
        chk("irq_clr", irq_o, 1'b0);
        rd(IDX_IRQ_FLAG);
        chk("flag_clr", q, 8'h00);
        ref_low <= 1'b0;
        wr(IDX_XTAL2, 8'h00);
        @(posedge clk_i);
        ref_low <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(IDX_IRQ_FLAG);
        chk("leak_off", q, 8'h00);
        // A reset in mid-run must clear irq, the converter enables, the source and the gain register.
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk("rst_out", {irq_o, cen_o, src_o}, 5'b00000);
        rd(IDX_GAIN);
        chk("rst_gain", q, REG_RST);
        end_of_test();
    end
endmodule
